// ===== design/edpc_pkg.sv
// Package: register index, bit positions, reset value and write mask for the pin control block
package edpc_pkg;
    localparam logic [7:0] EDPC_CTRL_INDEX = 8'h08;  // Register index on the sequencer data port
    localparam logic [7:0] EDPC_CTRL_RESET = 8'h00;  // Control reset value
    localparam int EDPC_B_SEL        = 0;  // Select output / select drive
    localparam int EDPC_B_DIN_EN     = 1;  // Data-in readback enable / data-in drive
    localparam int EDPC_B_CLK        = 2;  // Shift clock value / select readback
    localparam int EDPC_B_DATA       = 3;  // Data toward the EEPROM
    localparam int EDPC_B_OUT_EN     = 4;  // Turn ext pins into outputs
    localparam int EDPC_B_LATCH      = 5;  // Latch ext pin levels
    localparam int EDPC_B_MODE       = 6;  // DDC mode / 16-bit acknowledge disable
    localparam int EDPC_B_DIN_RB     = 7;  // Data-in readback
    // Which bits software may store
    localparam logic [7:0] EDPC_WR_MASK = 8'h7f;
endpackage

// ===== design/edpc_pins_if.sv
// Interface: pin-side signals between the control register and the pin driver
`timescale 1ns/1ns
interface edpc_pins_if;
    logic [7:0] ctrl;      // Stored control bits
    logic       pci_cfg;   // 1 on PCI or local-bus configuration
    modport regs (output ctrl, output pci_cfg);
    modport pins (input ctrl, input pci_cfg);
endinterface

// ===== design/edpc_pin_drive.sv
// Pin driver: computes next pin drive values from the control bits
`timescale 1ns/1ns
module edpc_pin_drive
    import edpc_pkg::*;
(
    edpc_pins_if.pins bus,          // Control bits from the register
    input  wire logic ddc_mode,     // Qualified DDC mode
    output logic      sel_o,        // Select pin output value
    output logic      sel_oe,       // Select pin output enable
    output logic      din_o,        // Data-in pin output value
    output logic      din_oe,       // Data-in pin output enable
    output logic      sync_o,       // Ext sync pin output value
    output logic      video_o,      // Ext video pin output value
    output logic      ext_oe        // Ext pins output enable
);
    // Pure combinational; the top registers the results
    always_comb begin
        if (ddc_mode && bus.pci_cfg) begin
            sel_o   = 1'b0;
            sel_oe  = ~bus.ctrl[EDPC_B_SEL];
            din_o   = 1'b0;
            din_oe  = ~bus.ctrl[EDPC_B_DIN_EN];
            ext_oe  = 1'b0;
        end else begin
            sel_o   = bus.ctrl[EDPC_B_SEL];
            sel_oe  = 1'b1;
            din_o   = 1'b0;
            din_oe  = 1'b0;
            ext_oe  = bus.ctrl[EDPC_B_OUT_EN];
        end
        sync_o  = bus.ctrl[EDPC_B_CLK];
        video_o = bus.ctrl[EDPC_B_DATA];
    end
endmodule

// ===== design/edpc_top.sv
// Top: EEPROM / DDC pin control register with indexed host port
//
// Overview of operation
// - On PCI or local-bus configurations bit 6 selects EEPROM meanings at 0 and DDC meanings at 1.
// - On ISA configurations bit 6 at 1 suppresses the 16-bit memory acknowledge.
// - In EEPROM mode bit 7 reads the data-in pin only while bit 1 is set, else zero.
// - In DDC mode bit 7 always reads the data-in pin.
// - In EEPROM mode bit 5 at 1 latches the ext pin levels that steer the video drivers.
// - In EEPROM mode bit 4 turns both ext pins into outputs, else they stay inputs.
// - With bit 4 set in EEPROM mode the ext video pin carries bit 3.
// - With bit 4 set in EEPROM mode the ext sync pin carries bit 2 as shift clock.
// - In DDC mode bit 2 is read-only and shows the select pin level.
// - In EEPROM mode bit 1 routes the data-in pin to readback bit 7.
// - In DDC mode bit 1 at 0 drives data-in low, at 1 releases it.
// - In EEPROM mode the select pin carries bit 0.
// - In DDC mode bit 0 at 0 drives select low, at 1 releases it.
// - In DDC mode bits 5, 4 and 3 have no function.
`timescale 1ns/1ns
module edpc_top
    import edpc_pkg::*;
(
    input  wire logic       mclk,          // Register clock, 100 MHz
    input  wire logic       rst,           // Asynchronous reset, active high
    input  wire logic       pci_cfg,       // 1 = PCI/local bus, 0 = ISA
    input  wire logic [7:0] io_index,      // Sequencer index register value
    input  wire logic       io_wr,         // Data port write strobe
    input  wire logic       io_rd,         // Data port read strobe
    input  wire logic [7:0] io_wdata,      // Write data
    output logic      [7:0] io_rdata,      // Read data, valid cycle after io_rd
    input  wire logic       mcs16_req_n,   // Core 16-bit memory acknowledge request
    output logic            mcs16_n,       // 16-bit memory acknowledge, active low
    input  wire logic       sel_i,         // Select pin level
    output logic            sel_o,         // Select pin output value
    output logic            sel_oe,        // Select pin output enable
    input  wire logic       din_i,         // Data-in pin level
    output logic            din_o,         // Data-in pin output value
    output logic            din_oe,        // Data-in pin output enable
    input  wire logic       sync_i,        // Ext sync pin level
    output logic            sync_o,        // Ext sync pin output value
    input  wire logic       video_i,       // Ext video pin level
    output logic            video_o,       // Ext video pin output value
    output logic            ext_oe,        // Ext pins output enable
    output logic            sync_ctrl,     // Sync/blank driver control
    output logic            video_ctrl     // Pixel bus driver control
);
    edpc_pins_if pif ();

    logic [7:0] ctrl_reg, ctrl_next;
    logic [7:0] rdata_reg, rdata_next;
    logic       sync_lat_reg, sync_lat_next;
    logic       video_lat_reg, video_lat_next;
    logic       mcs16_reg, mcs16_next;
    logic       sel_o_reg, sel_oe_reg, din_o_reg, din_oe_reg;
    logic       sync_o_reg, video_o_reg, ext_oe_reg;
    logic       sync_ctrl_reg, sync_ctrl_next, video_ctrl_reg, video_ctrl_next;
    logic       sel_o_c, sel_oe_c, din_o_c, din_oe_c, sync_o_c, video_o_c, ext_oe_c;
    logic       ddc_mode;
    logic       hit;

    assign pif.ctrl    = ctrl_reg;
    assign pif.pci_cfg = pci_cfg;

    // Bit 6 only switches meanings on PCI/local bus; on ISA it is the acknowledge disable
    assign ddc_mode = pci_cfg & ctrl_reg[EDPC_B_MODE];
    assign hit      = (io_index == EDPC_CTRL_INDEX);

    edpc_pin_drive u_drive (
        .bus     (pif.pins),
        .ddc_mode(ddc_mode),
        .sel_o   (sel_o_c),
        .sel_oe  (sel_oe_c),
        .din_o   (din_o_c),
        .din_oe  (din_oe_c),
        .sync_o  (sync_o_c),
        .video_o (video_o_c),
        .ext_oe  (ext_oe_c)
    );

    // Readback mixes stored bits with live pin levels
    function automatic logic [7:0] rd_value(input logic [7:0] c, input logic ddc,
                                            input logic din, input logic sel);
        logic [7:0] v;
        v = c & EDPC_WR_MASK;
        if (ddc) begin
            v[EDPC_B_DIN_RB] = din;
            v[EDPC_B_CLK]    = sel;
        end else begin
            v[EDPC_B_DIN_RB] = din & c[EDPC_B_DIN_EN];
        end
        return v;
    endfunction

    // Register write and read path
    always_comb begin
        ctrl_next  = ctrl_reg;
        rdata_next = rdata_reg;
        if (io_wr && hit) begin
            ctrl_next = io_wdata & EDPC_WR_MASK;
            // Select readback is read-only in DDC mode; keep the stored bit
            if (ddc_mode) begin
                ctrl_next[EDPC_B_CLK] = ctrl_reg[EDPC_B_CLK];
            end
        end
        if (io_rd) begin
            rdata_next = hit ? rd_value(ctrl_reg, ddc_mode, din_i, sel_i) : 8'h00;
        end
    end

    // Latches follow the pins until bit 5 freezes them
    always_comb begin
        sync_lat_next  = sync_lat_reg;
        video_lat_next = video_lat_reg;
        if (ddc_mode || !ctrl_reg[EDPC_B_LATCH]) begin
            sync_lat_next  = sync_i;
            video_lat_next = video_i;
        end
        // Latched value steers drivers; software keeps bit 5 set while outputs on
        if (!ddc_mode && ctrl_reg[EDPC_B_LATCH]) begin
            sync_ctrl_next  = sync_lat_reg;
            video_ctrl_next = video_lat_reg;
        end else begin
            sync_ctrl_next  = sync_i;
            video_ctrl_next = video_i;
        end
        // ISA: bit 6 masks the acknowledge; software owns the block-transfer hazard
        mcs16_next = mcs16_req_n | (~pci_cfg & ctrl_reg[EDPC_B_MODE]);
    end

    // All state and registered outputs
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_reg       <= EDPC_CTRL_RESET;
            rdata_reg      <= 8'h00;
            sync_lat_reg   <= 1'b0;
            video_lat_reg  <= 1'b0;
            mcs16_reg      <= 1'b1;
            sel_o_reg      <= 1'b0;
            sel_oe_reg     <= 1'b0;
            din_o_reg      <= 1'b0;
            din_oe_reg     <= 1'b0;
            sync_o_reg     <= 1'b0;
            video_o_reg    <= 1'b0;
            ext_oe_reg     <= 1'b0;
            sync_ctrl_reg  <= 1'b0;
            video_ctrl_reg <= 1'b0;
        end else begin
            ctrl_reg       <= ctrl_next;
            rdata_reg      <= rdata_next;
            sync_lat_reg   <= sync_lat_next;
            video_lat_reg  <= video_lat_next;
            mcs16_reg      <= mcs16_next;
            sel_o_reg      <= sel_o_c;
            sel_oe_reg     <= sel_oe_c;
            din_o_reg      <= din_o_c;
            din_oe_reg     <= din_oe_c;
            sync_o_reg     <= sync_o_c;
            video_o_reg    <= video_o_c;
            ext_oe_reg     <= ext_oe_c;
            sync_ctrl_reg  <= sync_ctrl_next;
            video_ctrl_reg <= video_ctrl_next;
        end
    end

    assign io_rdata   = rdata_reg;
    assign mcs16_n    = mcs16_reg;
    assign sel_o      = sel_o_reg;
    assign sel_oe     = sel_oe_reg;
    assign din_o      = din_o_reg;
    assign din_oe     = din_oe_reg;
    assign sync_o     = sync_o_reg;
    assign video_o    = video_o_reg;
    assign ext_oe     = ext_oe_reg;
    assign sync_ctrl  = sync_ctrl_reg;
    assign video_ctrl = video_ctrl_reg;

    // Checks
    a_rd_din_eeprom: assert property (@(posedge mclk) disable iff (rst)
        (io_rd && hit && !ddc_mode && !ctrl_reg[EDPC_B_DIN_EN]) |=> io_rdata[7] == 1'b0)
        else $error("Data-in readback not zero");
    a_rd_din_ddc: assert property (@(posedge mclk) disable iff (rst)
        (io_rd && hit && ddc_mode) |=> io_rdata[7] == $past(din_i))
        else $error("DDC data-in readback wrong");
    a_rd_din_route: assert property (@(posedge mclk) disable iff (rst)
        (io_rd && hit && !ddc_mode && ctrl_reg[EDPC_B_DIN_EN]) |=> io_rdata[7] == $past(din_i))
        else $error("Data-in routing wrong");
    a_rd_sel_ddc: assert property (@(posedge mclk) disable iff (rst)
        (io_rd && hit && ddc_mode) |=> io_rdata[2] == $past(sel_i))
        else $error("Select readback wrong");
    a_mcs16_mask: assert property (@(posedge mclk) disable iff (rst)
        (!pci_cfg && ctrl_reg[EDPC_B_MODE]) |=> mcs16_n)
        else $error("Acknowledge not suppressed");
    a_ext_oe_mode: assert property (@(posedge mclk) disable iff (rst)
        ddc_mode |=> !ext_oe)
        else $error("Ext pins driven in DDC mode");
    a_ext_data_drv: assert property (@(posedge mclk) disable iff (rst)
        (!ddc_mode && ctrl_reg[EDPC_B_OUT_EN]) |=> ext_oe && video_o == $past(ctrl_reg[3]))
        else $error("Video pin data wrong");
    a_ext_clk_drv: assert property (@(posedge mclk) disable iff (rst)
        (!ddc_mode && ctrl_reg[EDPC_B_OUT_EN]) |=> sync_o == $past(ctrl_reg[2]))
        else $error("Shift clock wrong");
    a_sel_eeprom: assert property (@(posedge mclk) disable iff (rst)
        !ddc_mode |=> sel_oe && sel_o == $past(ctrl_reg[0]))
        else $error("Select pin wrong");
    a_sel_ddc_od: assert property (@(posedge mclk) disable iff (rst)
        ddc_mode |=> !sel_o && sel_oe == !$past(ctrl_reg[0]))
        else $error("Select open drain wrong");
    a_din_ddc_od: assert property (@(posedge mclk) disable iff (rst)
        ddc_mode |=> !din_o && din_oe == !$past(ctrl_reg[1]))
        else $error("Data-in open drain wrong");
    a_latch_hold: assert property (@(posedge mclk) disable iff (rst)
        (!ddc_mode && ctrl_reg[EDPC_B_LATCH] && $stable(ctrl_reg))
        |=> $stable(sync_lat_reg) && $stable(video_lat_reg))
        else $error("Latch not held");
    a_ctrl_direct: assert property (@(posedge mclk) disable iff (rst)
        (!ddc_mode && !ctrl_reg[EDPC_B_LATCH])
        |=> sync_ctrl == $past(sync_i) && video_ctrl == $past(video_i))
        else $error("Driver control not following pins");
    // Checked from the raw bits, so a broken mode decode cannot hide behind itself
    a_mode_select: assert property (@(posedge mclk) disable iff (rst)
        pci_cfg |=> sel_oe == ($past(ctrl_reg[EDPC_B_MODE]) ? !$past(ctrl_reg[EDPC_B_SEL]) : 1'b1))
        else $error("Mode decode wrong");
    a_sel_rb_ro: assert property (@(posedge mclk) disable iff (rst)
        (io_wr && hit && ddc_mode) |=> ctrl_reg[EDPC_B_CLK] == $past(ctrl_reg[EDPC_B_CLK]))
        else $error("Select readback bit written");
    a_reserved_bits: assert property (@(posedge mclk) disable iff (rst)
        (ddc_mode && $changed(ctrl_reg[5:3])) |=> !ext_oe)
        else $error("Reserved bits have effect");
endmodule

// ===== sim/edpc_far_model.sv
// Far-side model: EEPROM or DDC monitor lines with their pull-ups
`timescale 1ns/1ns
module edpc_far_model (
    input  wire logic sel_o,     // Select drive value
    input  wire logic sel_oe,    // Select drive enable
    input  wire logic din_o,     // Data-in drive value
    input  wire logic din_oe,    // Data-in drive enable
    input  wire logic sync_o,    // Ext sync drive value
    input  wire logic video_o,   // Ext video drive value
    input  wire logic ext_oe,    // Ext pins drive enable
    input  wire logic far_sel,   // Far select level, 1 = released
    input  wire logic far_din,   // Far data level, 1 = released
    input  wire logic far_sync,  // Video source level on ext sync
    input  wire logic far_video, // Video source level on ext video
    output logic      sel_i,     // Resolved select line
    output logic      din_i,     // Resolved data line
    output logic      sync_i,    // Resolved ext sync line
    output logic      video_i    // Resolved ext video line
);
    // Open-drain lines: a released driver leaves the pull-up, either side may pull low
    assign sel_i = (sel_oe ? sel_o : 1'b1) & far_sel;
    assign din_i = (din_oe ? din_o : 1'b1) & far_din;
    // Video source lets go of the ext pins while the block drives them
    assign sync_i  = ext_oe ? sync_o : far_sync;
    assign video_i = ext_oe ? video_o : far_video;
endmodule

// ===== sim/tb_top.sv
// Testbench: register port and pin checks for the pin control block
`timescale 1ns/1ns
module tb_top;
    import edpc_pkg::*;
    localparam logic [7:0] ix = EDPC_CTRL_INDEX;
    logic       mclk = 0, rst = 1, pci_cfg = 1, io_wr = 0, io_rd = 0, mcs16_req_n = 1;
    logic [7:0] io_index = 8'h00, io_wdata = 8'h00, io_rdata;
    logic       sel_i, sel_o, sel_oe, din_i, din_o, din_oe, sync_i, sync_o;
    logic       video_i, video_o, ext_oe, sync_ctrl, video_ctrl, mcs16_n;
    logic       far_sel = 1, far_din = 1, far_sync = 0, far_video = 0;
    int         err_count = 0, n_compared = 0, cycles = 0;

    edpc_top dut (.mclk, .rst, .pci_cfg, .io_index, .io_wr, .io_rd, .io_wdata, .io_rdata,
        .mcs16_req_n, .mcs16_n, .sel_i, .sel_o, .sel_oe, .din_i, .din_o, .din_oe, .sync_i,
        .sync_o, .video_i, .video_o, .ext_oe, .sync_ctrl, .video_ctrl);
    edpc_far_model far (.sel_o, .sel_oe, .din_o, .din_oe, .sync_o, .video_o, .ext_oe,
        .far_sel, .far_din, .far_sync, .far_video, .sel_i, .din_i, .sync_i, .video_i);

    // Clock, plus a hang guard well above the hundred or so cycles the tests need
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            err_count++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Write strobe for one cycle, then let pins settle two edges later
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        io_index = idx;
        io_wdata = d;
        io_wr = 1;
        @(posedge mclk);
        #1 io_wr = 0;
        repeat (2) @(posedge mclk);
        #1;
    endtask

    // Read data lands at the edge that takes the strobe
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        io_index = idx;
        io_rd = 1;
        @(posedge mclk);
        #1 io_rd = 0;
        chk(io_rdata, exp);
        // Let an edge pass so a following read never re-raises the strobe in this time step
        @(posedge mclk);
        #1;
    endtask

    task automatic idle;
        repeat (2) @(posedge mclk);
        #1;
    endtask

    task automatic tally_and_finish;
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Main sequence: EEPROM mode, latching, unmapped index, DDC mode, ISA
    initial begin
        repeat (20) @(posedge mclk);
        #1 rst = 0;
        idle();
        chk({4'h0, sel_o, sel_oe, din_oe, ext_oe}, 8'h04);
        rd(ix, 8'h00);
        wr(ix, 8'h01);
        chk({4'h0, sel_o, sel_oe, din_oe, ext_oe}, 8'h0c);
        rd(ix, 8'h01);
        wr(ix, 8'h82);
        rd(ix, 8'h82);
        far_din = 0;
        rd(ix, 8'h02);
        far_din = 1;
        far_sync = 1;
        // Latch first, then enable outputs, and undo in reverse order
        wr(ix, 8'h20);
        far_sync = 0;
        far_video = 1;
        idle();
        chk({3'h0, ext_oe, sync_o, video_o, sync_ctrl, video_ctrl}, 8'h02);
        wr(ix, 8'h3c);
        chk({3'h0, ext_oe, sync_i, video_i, sync_ctrl, video_ctrl}, 8'h1e);
        wr(ix, 8'h34);
        chk({3'h0, ext_oe, sync_i, video_i, sync_ctrl, video_ctrl}, 8'h1a);
        wr(ix, 8'h38);
        chk({3'h0, ext_oe, sync_i, video_i, sync_ctrl, video_ctrl}, 8'h16);
        wr(ix, 8'h20);
        chk({3'h0, ext_oe, sync_o, video_o, sync_ctrl, video_ctrl}, 8'h02);
        wr(ix, 8'h00);
        chk({6'h0, sync_ctrl, video_ctrl}, 8'h01);
        wr(8'h09, 8'hff);
        rd(8'h09, 8'h00);
        rd(ix, 8'h00);
        // DDC mode: open-drain select and data lines
        wr(ix, 8'h40);
        chk({3'h0, din_o, sel_o, sel_oe, din_oe, ext_oe}, 8'h06);
        rd(ix, 8'h40);
        wr(ix, 8'h43);
        chk({6'h0, sel_oe, din_oe}, 8'h00);
        rd(ix, 8'hc7);
        far_din = 0;
        far_sel = 0;
        rd(ix, 8'h43);
        far_din = 1;
        wr(ix, 8'h7f);
        chk({7'h0, ext_oe}, 8'h00);
        rd(ix, 8'hfb);
        // Clear the reserved bits first, so the ISA switch never turns the ext pins on unlatched
        wr(ix, 8'h43);
        // ISA: bit 6 only gates the 16-bit acknowledge
        far_sel = 1;
        pci_cfg = 0;
        mcs16_req_n = 0;
        wr(ix, 8'h43);
        chk({7'h0, mcs16_n}, 8'h01);
        chk({4'h0, sel_o, sel_oe, din_oe, ext_oe}, 8'h0c);
        rd(ix, 8'hc3);
        wr(ix, 8'h03);
        chk({7'h0, mcs16_n}, 8'h00);
        mcs16_req_n = 1;
        idle();
        chk({7'h0, mcs16_n}, 8'h01);
        // Reset in mid-run must clear the register and the select drive again
        rst = 1;
        idle();
        rst = 0;
        idle();
        chk({4'h0, sel_o, sel_oe, din_oe, ext_oe}, 8'h04);
        rd(ix, 8'h00);
        tally_and_finish();
    end
endmodule
